// ### sim/apm_core_model.sv
// Processor core and wake source model facing the power-mode controller
module apm_core_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cmd_sleep,
   input wire logic [3:0] cmd_wake,
   output logic cpu_sleep_req,
   output logic wake_net,
   output logic wake_timer,
   output logic wake_pad,
   output logic wake_rtc
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sleep request is a single-cycle pulse launched by the core
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_sleep_req <= 1'b0;
      end else begin
         cpu_sleep_req <= cmd_sleep;
      end
   end
   // Wake sources hold their level until the bench withdraws them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {wake_rtc, wake_pad, wake_timer, wake_net} <= 4'h0;
      end else begin
         {wake_rtc, wake_pad, wake_timer, wake_net} <= cmd_wake;
      end
   end
endmodule : apm_core_model

// ### sim/apm_ctrl_tb_top.sv
// Self-checking bench for the power-mode controller
module apm_ctrl_tb_top;
   import apm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, ret0, ret1, aon_cfg, rnd = 32'h8DDB5E9C;
   logic pready, pslverr, cpu_sleep_req, wake_net, wake_timer, wake_pad, wake_rtc;
   logic net_sleep_req = 0, net_sleep_ack, cpu_clk_en, sys_clk_en, pll_en;
   logic cpu_rst_n, periph_rst_n, irq, cmd_sleep = 0;
   logic [3:0] cmd_wake = 4'h0;
   logic [7:0] wake_gpio = 8'h00, sram_pwr;
   logic [64:0] exp_q[$];
   int bad_count = 0, checks_done = 0, cyc = 0, n;
   always #2 clk = ~clk;
   apm_core_model u_core (.clk(clk), .reset_n(reset_n), .cmd_sleep(cmd_sleep),
      .cmd_wake(cmd_wake), .cpu_sleep_req(cpu_sleep_req), .wake_net(wake_net),
      .wake_timer(wake_timer), .wake_pad(wake_pad), .wake_rtc(wake_rtc));
   apm_ctrl #(.GPIO_W(8), .RAMP_CYC(4)) u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_sleep_req(cpu_sleep_req), .wake_net(wake_net),
      .wake_timer(wake_timer), .wake_pad(wake_pad), .wake_rtc(wake_rtc),
      .wake_gpio(wake_gpio), .net_sleep_req(net_sleep_req), .net_sleep_ack(net_sleep_ack),
      .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .pll_en(pll_en),
      .sram_pwr(sram_pwr), .cpu_rst_n(cpu_rst_n), .periph_rst_n(periph_rst_n),
      .aon_cfg(aon_cfg), .ret0(ret0), .ret1(ret1), .irq(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
         bad_count++;
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   // One APB transfer; the expected answer is noted before the request goes out
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic e);
      exp_q.push_back({e, m, d});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d, 32'h0, e);
   endtask : wr
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   // Select a mode and let the core ask for it with one pulse
   task automatic sleep(input logic [1:0] md);
      wr(APM_CTRL_OFF, {30'h0, md}, 1'b0);
      @(posedge clk) cmd_sleep <= 1'b1;
      @(posedge clk) cmd_sleep <= 1'b0;
      tick(4);
   endtask : sleep
   // Bounded wait for the processor clock to come back
   task automatic wait_on();
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      @(posedge clk);
      cmd_wake <= 4'h0;
      wake_gpio <= 8'h00;
      tick(2);
   endtask : wait_on
   // Watcher: every completed transfer takes the oldest note off the queue
   always @(posedge clk) begin
      logic [64:0] ent;
      if (psel && penable && pready && exp_q.size() > 0) begin
         ent = exp_q.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, ent[64]});
         check("prdata", prdata & ent[63:32], ent[31:0] & ent[63:32]);
      end
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      tick(2);
      check("clk_en", {cpu_clk_en, sys_clk_en, pll_en, cpu_rst_n, periph_rst_n}, 5'h1F);
      check("sram_pwr", sram_pwr, APM_SRAM_KEEP_RST);
      apb(1'b0, APM_CTRL_OFF, APM_CTRL_RST, 32'h3, 1'b0);
      apb(1'b0, APM_WAKE_EN_OFF, 32'h0, 32'h1F, 1'b0);
      apb(1'b0, 8'h28, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 8'h02, 32'h0, 32'h0, 1'b1);
      $display("test reset done");
      // Hibernate with no wake source enabled is refused
      wr(APM_IRQ_MASK_OFF, 32'h7, 1'b0);
      sleep(APM_MODE_HIB);
      check("no_hib", cpu_clk_en, 1);
      check("irq", irq, 1);
      apb(1'b0, APM_IRQ_STAT_OFF, 32'h4, 32'h7, 1'b0);
      tick(1);
      check("irq_clr", irq, 0);
      $display("test bad request done");
      // Light sleep: only the processor clock stops, disabled events ignored
      wr(APM_WAKE_EN_OFF, 32'h2, 1'b0);
      sleep(APM_MODE_LIGHT);
      check("light", {cpu_clk_en, sys_clk_en, pll_en}, 3'h3);
      wr(APM_AON_CFG_OFF, 32'h5, 1'b1);
      @(posedge clk) cmd_wake <= 4'h1;
      tick(6);
      check("no_wake", cpu_clk_en, 0);
      @(posedge clk) cmd_wake <= 4'h2;
      wait_on();
      check("light_wake", cpu_clk_en, 1);
      check("irq_woke", irq, 1);
      apb(1'b0, APM_IRQ_STAT_OFF, 32'h1, 32'h7, 1'b0);
      // Status shows the running state and the timer as wake source
      apb(1'b0, APM_STATUS_OFF, 32'h201, 32'h73F, 1'b0);
      $display("test light sleep done");
      // Clock-stopped state halts system clock and PLL
      wr(APM_WAKE_EN_OFF, 32'h2, 1'b0);
      sleep(APM_MODE_CLKSTOP);
      check("clkstop", {cpu_clk_en, sys_clk_en, pll_en}, 3'h0);
      @(posedge clk) cmd_wake <= 4'h2;
      wait_on();
      check("clkstop_wake", {sys_clk_en, pll_en}, 2'h3);
      $display("test clock stop done");
      // Retentive state keeps chosen banks and always-on settings
      rnd = lfsr(rnd);
      wr(APM_AON_CFG_OFF, rnd, 1'b0);
      wr(APM_SRAM_KEEP_OFF, 32'h0F, 1'b0);
      wr(APM_WAKE_EN_OFF, 32'h4, 1'b0);
      sleep(APM_MODE_RETAIN);
      check("sram_keep", sram_pwr, 8'h0F);
      check("rst_held", {cpu_rst_n, periph_rst_n}, 2'h0);
      @(posedge clk) cmd_wake <= 4'h4;
      wait_on();
      check("exit_fast", n < 12, 1);
      check("rst_free", {cpu_rst_n, periph_rst_n}, 2'h3);
      check("aon_kept", aon_cfg, rnd);
      apb(1'b0, APM_AON_CFG_OFF, rnd, 32'hFFFFFFFF, 1'b0);
      apb(1'b0, APM_IRQ_STAT_OFF, 32'h1, 32'h7, 1'b0);
      $display("test retention done");
      // Hibernate left by the RTC, then by a selected GPIO
      for (int k = 0; k < 2; k++) begin
         rnd = lfsr(rnd);
         wr(APM_RET0_OFF, rnd, 1'b0);
         wr(APM_RET1_OFF, ~rnd, 1'b0);
         wr(APM_GPIO_SEL_OFF, 32'h04, 1'b0);
         wr(APM_WAKE_EN_OFF, 32'h19, 1'b0);
         sleep(APM_MODE_HIB);
         check("hib_sram", sram_pwr, 8'h00);
         @(posedge clk) cmd_wake <= 4'h3;
         wake_gpio <= 8'h02;
         tick(8);
         check("hib_stay", cpu_clk_en, 0);
         @(posedge clk);
         if (k == 0) cmd_wake <= 4'h8;
         else wake_gpio <= 8'h04;
         wait_on();
         check("hib_exit", cpu_clk_en, 1);
         check("ret0", ret0, rnd);
         check("ret1", ret1, ~rnd);
         check("aon_wiped", aon_cfg, 32'h0);
         // Hibernate exit flags itself, then the ramp back to run flags a wake
         apb(1'b0, APM_IRQ_STAT_OFF, 32'h3, 32'h7, 1'b0);
         apb(1'b0, APM_STATUS_OFF, 32'h701, 32'h73F, 1'b0);
      end
      $display("test hibernate done");
      // Other subsystem sleeps without touching the processor
      @(posedge clk) net_sleep_req <= 1'b1;
      tick(3);
      check("net_ack", net_sleep_ack, 1);
      check("cpu_run", {cpu_clk_en, sys_clk_en}, 2'h3);
      @(posedge clk) net_sleep_req <= 1'b0;
      tick(3);
      check("net_ack_off", net_sleep_ack, 0);
      $display("test subsystem sleep done");
      final_report();
   end
endmodule : apm_ctrl_tb_top

// ### src/apm_ctrl.sv
// Power-mode controller for the application processor subsystem
// How it works
// RULE1: Light sleep gates only the processor clock
// RULE2: Clock-stopped state halts system clock and PLL
// RULE3: Retentive state keeps selected SRAM banks, 256 KB
// RULE4: Retentive state exit completes under 5 ms
// RULE5: Retentive state resets processor and peripheral registers
// RULE6: Always-on configuration survives the retentive state
// RULE7: Hibernate exits only on RTC or selected GPIO
// RULE8: Hibernate keeps only two 32-bit registers; the code also keeps the interrupt status across hibernate
// RULE9: Software selects which events wake the processor
// RULE10: Other subsystem power changes stay invisible here
// RULE11: Enabled wake event in light sleep restarts clock; the code ends light sleep only on enabled net, timer or pad events
//
// Register access over APB and the register offsets were decided locally.
module apm_ctrl
   import apm_pkg::*;
#(
   parameter int GPIO_W = 8,
   parameter int RAMP_CYC = int'(APM_RETAIN_EXIT_CYC) - 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_sleep_req,
   input wire logic wake_net,
   input wire logic wake_timer,
   input wire logic wake_pad,
   input wire logic wake_rtc,
   input wire logic [GPIO_W-1:0] wake_gpio,
   input wire logic net_sleep_req,
   output logic net_sleep_ack,
   output logic cpu_clk_en,
   output logic sys_clk_en,
   output logic pll_en,
   output logic [APM_BANKS-1:0] sram_pwr,
   output logic cpu_rst_n,
   output logic periph_rst_n,
   output logic [31:0] aon_cfg,
   output logic [31:0] ret0,
   output logic [31:0] ret1,
   output logic irq
);
   apm_state_t state;
   apm_state_t next_state;
   logic [31:0] ctrl;
   logic [4:0] wake_en;
   logic [GPIO_W-1:0] gpio_sel;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [APM_BANKS-1:0] sram_keep;
   logic [2:0] wake_src;
   logic [31:0] ramp_cnt;
   logic wr_acc;
   logic rd_acc;
   logic regs_up;
   logic run_hit;
   logic hib_hit;
   logic woke_evt;
   logic hib_exit;
   logic bad_req;
   logic hib_wipe;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= APM_SRAM_KEEP_OFF;
   endfunction : mapped

   // Bus phases; registers take writes only in the run state, reads answer in any state
   assign regs_up = state == APM_ST_RUN;
   assign wr_acc = psel && penable && pwrite && regs_up && mapped(paddr);
   assign rd_acc = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && (!mapped(paddr) || (pwrite && !regs_up));

   // Wake event decode
   assign run_hit = (wake_en[APM_WK_NET] && wake_net) || // RULE9
      (wake_en[APM_WK_TIMER] && wake_timer) ||
      (wake_en[APM_WK_PAD] && wake_pad);
   assign hib_hit = (wake_en[APM_WK_RTC] && wake_rtc) || // RULE7
      (wake_en[APM_WK_GPIO] && |(wake_gpio & gpio_sel));
   assign bad_req = cpu_sleep_req && state == APM_ST_RUN && ctrl[1:0] == APM_MODE_HIB &&
      !(wake_en[APM_WK_RTC] || wake_en[APM_WK_GPIO]);

   // Next power state
   always_comb begin
      next_state = state;
      unique case (state)
         APM_ST_RUN: begin
            if (cpu_sleep_req && !bad_req) begin
               unique case (ctrl[1:0])
                  APM_MODE_LIGHT: next_state = APM_ST_LIGHT;
                  APM_MODE_CLKSTOP: next_state = APM_ST_CLKSTOP;
                  APM_MODE_RETAIN: next_state = APM_ST_RETAIN;
                  APM_MODE_HIB: next_state = APM_ST_HIB;
               endcase
            end
         end
         APM_ST_LIGHT: if (run_hit) next_state = APM_ST_RUN; // RULE11
         APM_ST_CLKSTOP: if (run_hit) next_state = APM_ST_RUN;
         APM_ST_RETAIN: if (run_hit) next_state = APM_ST_WAKE;
         APM_ST_WAKE: if (ramp_cnt == 32'(RAMP_CYC - 1)) next_state = APM_ST_RUN; // RULE4
         APM_ST_HIB: if (hib_hit) next_state = APM_ST_WAKE; // RULE7
         default: next_state = APM_ST_RUN;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= APM_ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Power-up ramp counter for the exit from retention or hibernate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ramp_cnt <= '0;
      end else if (state == APM_ST_WAKE) begin
         ramp_cnt <= ramp_cnt + 32'h1;
      end else begin
         ramp_cnt <= '0;
      end
   end

   // Events for the interrupt status
   assign woke_evt = state != APM_ST_RUN && state != APM_ST_HIB && next_state == APM_ST_RUN;
   assign hib_exit = state == APM_ST_HIB && hib_hit;
   // Leaving hibernate wipes the control registers; the two retained words and the interrupt status are kept
   assign hib_wipe = hib_exit;

   // Clock and power controls
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_clk_en <= 1'b1;
         sys_clk_en <= 1'b1;
         pll_en <= 1'b1;
         sram_pwr <= '1;
         cpu_rst_n <= 1'b1;
         periph_rst_n <= 1'b1;
      end else begin
         cpu_clk_en <= next_state == APM_ST_RUN; // RULE1
         sys_clk_en <= next_state inside {APM_ST_RUN, APM_ST_LIGHT}; // RULE2
         pll_en <= next_state inside {APM_ST_RUN, APM_ST_LIGHT, APM_ST_WAKE}; // RULE2
         cpu_rst_n <= next_state inside {APM_ST_RUN, APM_ST_LIGHT, APM_ST_CLKSTOP}; // RULE5
         periph_rst_n <= next_state inside {APM_ST_RUN, APM_ST_LIGHT, APM_ST_CLKSTOP}; // RULE5
         if (next_state == APM_ST_HIB) begin
            sram_pwr <= '0; // RULE8
         end else if (next_state == APM_ST_RETAIN) begin
            sram_pwr <= sram_keep; // RULE3
         end else begin
            sram_pwr <= '1;
         end
      end
   end

   // Control registers lost in hibernate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= APM_CTRL_RST;
         wake_en <= APM_WAKE_EN_RST;
         gpio_sel <= '0;
         irq_mask <= '0;
         sram_keep <= APM_SRAM_KEEP_RST;
         aon_cfg <= '0;
      end else if (hib_wipe) begin
         ctrl <= APM_CTRL_RST; // RULE8
         wake_en <= APM_WAKE_EN_RST;
         gpio_sel <= '0;
         irq_mask <= '0;
         sram_keep <= APM_SRAM_KEEP_RST;
         aon_cfg <= '0;
      end else if (wr_acc) begin
         if (hit(paddr, APM_CTRL_OFF)) ctrl <= {30'h0, pwdata[1:0]};
         if (hit(paddr, APM_WAKE_EN_OFF)) wake_en <= pwdata[4:0]; // RULE9
         if (hit(paddr, APM_GPIO_SEL_OFF)) gpio_sel <= pwdata[GPIO_W-1:0];
         if (hit(paddr, APM_IRQ_MASK_OFF)) irq_mask <= pwdata[2:0];
         if (hit(paddr, APM_SRAM_KEEP_OFF)) sram_keep <= pwdata[APM_BANKS-1:0]; // RULE3
         if (hit(paddr, APM_AON_CFG_OFF)) aon_cfg <= pwdata; // RULE6
      end
   end

   // The two words that survive hibernate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ret0 <= '0;
         ret1 <= '0;
      end else if (wr_acc) begin
         if (hit(paddr, APM_RET0_OFF)) ret0 <= pwdata; // RULE8
         if (hit(paddr, APM_RET1_OFF)) ret1 <= pwdata; // RULE8
      end
   end

   // Last wake source: net, timer, pad, or rtc/gpio
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_src <= '0;
      end else if (state inside {APM_ST_LIGHT, APM_ST_CLKSTOP, APM_ST_RETAIN} && run_hit) begin
         wake_src <= {wake_en[APM_WK_PAD] && wake_pad, wake_en[APM_WK_TIMER] && wake_timer,
                      wake_en[APM_WK_NET] && wake_net};
      end else if (hib_exit) begin
         wake_src <= 3'h7;
      end
   end

   // Sticky interrupt status; a read clears it, a new event wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~((rd_acc && hit(paddr, APM_IRQ_STAT_OFF)) ? 3'h7 : 3'h0)) |
            {bad_req, hib_exit, woke_evt};
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // Read data captured in the setup cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         unique case (1'b1)
            hit(paddr, APM_CTRL_OFF): prdata <= ctrl;
            hit(paddr, APM_WAKE_EN_OFF): prdata <= {27'h0, wake_en};
            hit(paddr, APM_GPIO_SEL_OFF): prdata <= 32'(gpio_sel);
            hit(paddr, APM_STATUS_OFF): prdata <= {21'h0, wake_src, 2'h0, state};
            hit(paddr, APM_IRQ_STAT_OFF): prdata <= {29'h0, irq_stat};
            hit(paddr, APM_IRQ_MASK_OFF): prdata <= {29'h0, irq_mask};
            hit(paddr, APM_AON_CFG_OFF): prdata <= aon_cfg;
            hit(paddr, APM_RET0_OFF): prdata <= ret0;
            hit(paddr, APM_RET1_OFF): prdata <= ret1;
            hit(paddr, APM_SRAM_KEEP_OFF): prdata <= 32'(sram_keep);
            default: prdata <= '0;
         endcase
      end
   end

   // Network subsystem handshake, never reflected in registers or irq
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         net_sleep_ack <= 1'b0;
      end else begin
         net_sleep_ack <= net_sleep_req; // RULE10
      end
   end

   // Cycles spent ramping, for the exit time check
   int wake_cycles;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_cycles <= 0;
      end else if (state == APM_ST_WAKE) begin
         wake_cycles <= wake_cycles + 1;
      end else begin
         wake_cycles <= 0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_light_wake;
      state == APM_ST_LIGHT && run_hit;
   endsequence
   sequence s_resumed;
      state == APM_ST_RUN && cpu_clk_en && sys_clk_en;
   endsequence
   sequence s_retain_entry;
      state == APM_ST_RUN && cpu_sleep_req && ctrl[1:0] == APM_MODE_RETAIN;
   endsequence

   AST_LIGHT_GATE: assert property ( // RULE1
      state == APM_ST_LIGHT |-> !cpu_clk_en && sys_clk_en && pll_en)
      else $error("light sleep clock gating wrong");
   AST_CLKSTOP_OFF: assert property ( // RULE2
      state == APM_ST_CLKSTOP |-> !sys_clk_en && !pll_en)
      else $error("clock-stopped state left a clock running");
   AST_SRAM_KEEP: assert property ( // RULE3
      s_retain_entry |=> state == APM_ST_RETAIN && sram_pwr == $past(sram_keep))
      else $error("retained SRAM banks wrong");
   AST_EXIT_TIME: assert property ( // RULE4
      state == APM_ST_WAKE |-> wake_cycles < int'(APM_RETAIN_EXIT_CYC))
      else $error("retention exit too slow");
   AST_REGS_LOST: assert property ( // RULE5
      state == APM_ST_RETAIN |-> !cpu_rst_n && !periph_rst_n)
      else $error("registers held during retention");
   AST_AON_KEPT: assert property ( // RULE6
      state == APM_ST_RETAIN ##1 state == APM_ST_RETAIN |-> $stable(aon_cfg))
      else $error("always-on config changed in retention");
   AST_HIB_STAY: assert property ( // RULE7
      state == APM_ST_HIB && !hib_hit |=> state == APM_ST_HIB)
      else $error("hibernate left without rtc or gpio");
   AST_HIB_RET: assert property ( // RULE8
      hib_exit |-> (sram_pwr == '0) ##1
      (ctrl == APM_CTRL_RST && $stable(ret0) && $stable(ret1)))
      else $error("hibernate retention wrong");
   AST_WAKE_SEL: assert property ( // RULE9
      state == APM_ST_LIGHT && wake_net && !wake_en[APM_WK_NET] && !wake_timer && !wake_pad
      |=> state == APM_ST_LIGHT)
      else $error("disabled event woke processor");
   AST_NET_HIDDEN: assert property ( // RULE10
      $rose(net_sleep_req) && state == APM_ST_RUN |=> net_sleep_ack && state == APM_ST_RUN)
      else $error("subsystem change disturbed application");
   AST_LIGHT_RESUME: assert property ( // RULE11
      s_light_wake |=> s_resumed)
      else $error("light sleep wake did not restart clock");
endmodule : apm_ctrl

// ### src/apm_pkg.sv
// Shared constants for the application power-mode controller
package apm_pkg;
   // Register byte offsets
   localparam logic [7:0] APM_CTRL_OFF = 8'h00;
   localparam logic [7:0] APM_WAKE_EN_OFF = 8'h04;
   localparam logic [7:0] APM_GPIO_SEL_OFF = 8'h08;
   localparam logic [7:0] APM_STATUS_OFF = 8'h0C;
   localparam logic [7:0] APM_IRQ_STAT_OFF = 8'h10;
   localparam logic [7:0] APM_IRQ_MASK_OFF = 8'h14;
   localparam logic [7:0] APM_AON_CFG_OFF = 8'h18;
   localparam logic [7:0] APM_RET0_OFF = 8'h1C;
   localparam logic [7:0] APM_RET1_OFF = 8'h20;
   localparam logic [7:0] APM_SRAM_KEEP_OFF = 8'h24;
   // Low-power mode codes in CTRL[1:0]
   localparam logic [1:0] APM_MODE_LIGHT = 2'h0;
   localparam logic [1:0] APM_MODE_CLKSTOP = 2'h1;
   localparam logic [1:0] APM_MODE_RETAIN = 2'h2;
   localparam logic [1:0] APM_MODE_HIB = 2'h3;
   // Wake enable bit positions
   localparam int APM_WK_NET = 0;
   localparam int APM_WK_TIMER = 1;
   localparam int APM_WK_PAD = 2;
   localparam int APM_WK_RTC = 3;
   localparam int APM_WK_GPIO = 4;
   // Interrupt status bit positions
   localparam int APM_IRQ_WOKE = 0;
   localparam int APM_IRQ_HIB_EXIT = 1;
   localparam int APM_IRQ_BAD_REQ = 2;
   // Reset values
   localparam logic [31:0] APM_CTRL_RST = 32'h0000_0000;
   localparam logic [4:0] APM_WAKE_EN_RST = 5'h00;
   localparam logic [7:0] APM_SRAM_KEEP_RST = 8'hFF;
   // Retention bank size and count: eight banks of 32 KB give 256 KB
   localparam int APM_SRAM_KB = 256;
   localparam int APM_BANKS = 8;
   // Exit from the retentive state must finish in under this time
   localparam longint APM_RETAIN_EXIT_NS = 5_000_000;
   localparam longint APM_CLK_NS = 4;
   localparam longint APM_RETAIN_EXIT_CYC = APM_RETAIN_EXIT_NS / APM_CLK_NS;
   // Power state, one-hot
   typedef enum logic [5:0] {
      APM_ST_RUN = 6'h01,
      APM_ST_LIGHT = 6'h02,
      APM_ST_CLKSTOP = 6'h04,
      APM_ST_RETAIN = 6'h08,
      APM_ST_WAKE = 6'h10,
      APM_ST_HIB = 6'h20
   } apm_state_t;
endpackage : apm_pkg
